// ===== design/plcp_pkg.sv
package plcp_pkg;

  // Register word indices; the byte address of each register is four times its index.
  localparam logic [5:0] IDX_MODE_SELECT = 6'h00;
  localparam logic [5:0] IDX_OVERHEAD_CONTROL = 6'h01;
  localparam logic [5:0] IDX_TX_PATH_STATUS = 6'h02;
  localparam logic [5:0] IDX_TX_USER_OCTET = 6'h03;
  localparam logic [5:0] IDX_RX_STATUS = 6'h04;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h05;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h06;
  localparam logic [5:0] IDX_RX_USER_OCTET = 6'h07;
  localparam logic [5:0] IDX_ERROR_PATTERN = 6'h0c;

  // Reset values.
  localparam logic [7:0] RST_MODE_SELECT = 8'h00;
  localparam logic [7:0] RST_OVERHEAD_CONTROL = 8'h08;
  localparam logic [7:0] RST_TX_PATH_STATUS = 8'hf0;
  localparam logic [7:0] RST_TX_USER_OCTET = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] RST_ERROR_PATTERN = 8'h00;

  // Mode select fields.
  localparam int MAP_SEL_BIT = 7;
  localparam int TIMING_MSB = 6;
  localparam int TIMING_LSB = 5;
  localparam logic [7:0] MODE_SELECT_MASK = 8'he0;

  // Overhead control fields.
  localparam int ZERO_FRAMING_BIT = 7;
  localparam int ZERO_POI_BIT = 6;
  localparam int ZERO_PARITY_BIT = 5;
  localparam int ZERO_STUFF_BIT = 4;
  localparam int AUTO_REPORT_BIT = 3;
  localparam int INJ_FRAMING_BIT = 2;
  localparam int INJ_PARITY_BIT = 1;
  localparam int INJ_REPORT_BIT = 0;
  localparam logic [7:0] INJECT_MASK = 8'h07;

  // Path status octet fields.
  localparam int REPORT_MSB = 7;
  localparam int REPORT_LSB = 4;
  localparam int ALARM_BIT = 3;
  localparam int LINK_MSB = 2;

  // Received report classes.
  localparam logic [3:0] REPORT_MAX_COUNT = 4'h8;
  localparam logic [3:0] REPORT_ALL_ONES = 4'hf;

  // Framing octet patterns sent in normal operation.
  localparam logic [7:0] FRAMING_OCTET_1 = 8'hf6;
  localparam logic [7:0] FRAMING_OCTET_2 = 8'h28;

  // Frame counts.
  localparam logic [3:0] LOF_FRAMES = 4'h8;
  localparam logic [3:0] ALARM_FRAMES = 4'ha;
  localparam logic [4:0] TX_ALARM_HOLD_FRAMES = 5'h14;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TIMING_RX_LOCK,
    TIMING_EXT_8K,
    TIMING_FREE_RUN
  } tx_timing_mode_t;

  typedef enum logic {
    RD_IDLE,
    RD_RESP
  } rd_state_t;

  typedef struct packed {
    logic [7:0] framing_1;
    logic [7:0] framing_2;
    logic poi_zero;
    logic [7:0] parity;
    logic [7:0] cycle_stuff;
    logic [7:0] path_status;
    logic [7:0] user_octet;
  } tx_overhead_t;

  typedef struct packed {
    logic frame_pulse;
    logic in_frame;
    logic framing_err;
    logic poi_err;
    logic [3:0] parity_err_count;
    logic [7:0] path_status;
    logic [7:0] user_octet;
  } rx_frame_info_t;

endpackage

// ===== design/plcp_ctrl_status.sv
`timescale 1ns/1ns

// Contract
// - Each port instance exposes the same register set at the same offsets.
// - Mapping select bit: 1 picks PLCP mapping, 0 direct mapping; resets 0.
// - Timing field: 00 receive lock, 01/11 external 8 kHz, 10 free-run stuffing.
// - Auto report uses received parity count, else path status upper nibble; auto default.
// - Report injection puts pattern upper nibble into G1 upper nibble for one frame.
// - Injection bits self-clear after use; clearing beats a simultaneous write.
// - Software report value is sent only while auto reporting is off.
// - Path status register resets to F0, its report field all ones by default.
// - A changed alarm bit is sent for at least 20 frames.
// - Link status field of G1 comes from the software register field.
// - User octet sent each frame from a software register resetting to zero.
// - Out-of-frame bit is set while no correct frame structure is found.
// - Loss-of-frame sets after 8 out-of-frame frames, clears on valid framing.
// - Remote alarm sets after 10 high frames, clears after 10 low frames.
// - Event status bits latch occurrences and clear when their register is read.
// - State status bits show the live receive condition.
// - Event status bits raise interrupt bits on rising transitions only.
// - State status bits raise interrupt bits on both transitions.
// - Reading the interrupt status register clears its set bits.
// - One interrupt bit per receive condition, invalid and all-ones shared.
// - A captured receive user octet that differs from the stored one sets its interrupt bit.
// - A zero-reset enable register gates each interrupt bit onto the output.
// - The last received user octet is readable in a read-only register.
module plcp_ctrl_status (
  input wire logic mclk_in,                                // 250 MHz clock
  input wire logic reset_in,                               // Synchronous reset, high
  input wire logic awvalid_in,                             // Write address valid
  output logic awready_out,                                // Write address ready
  input wire logic [7:0] awaddr_in,                        // Write byte address
  input wire logic wvalid_in,                              // Write data valid
  output logic wready_out,                                 // Write data ready
  input wire logic [31:0] wdata_in,                        // Write data
  input wire logic [3:0] wstrb_in,                         // Write byte strobes
  output logic bvalid_out,                                 // Write response valid
  input wire logic bready_in,                              // Write response ready
  output logic [1:0] bresp_out,                            // Write response
  input wire logic arvalid_in,                             // Read address valid
  output logic arready_out,                                // Read address ready
  input wire logic [7:0] araddr_in,                        // Read byte address
  output logic rvalid_out,                                 // Read data valid
  input wire logic rready_in,                              // Read data ready
  output logic [31:0] rdata_out,                           // Read data
  output logic [1:0] rresp_out,                            // Read response
  input wire plcp_pkg::rx_frame_info_t rx_info_in,         // Receive frame results
  input wire logic tx_frame_start_in,                      // Transmit frame start pulse
  input wire logic [7:0] tx_parity_in,                     // Computed B1 for this frame
  input wire logic [7:0] tx_cycle_stuff_in,                // Computed C1 for this frame
  output plcp_pkg::tx_overhead_t tx_overhead_out,          // Overhead for current frame
  output logic plcp_mapping_select_out,                    // 1 PLCP, 0 direct mapping
  output plcp_pkg::tx_timing_mode_t tx_frame_timing_source_out, // Transmit frame timing
  output logic irq_out                                     // Enabled interrupt pending
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave state.

  logic aw_held;
  logic [5:0] aw_idx;
  logic w_held;
  logic [7:0] w_byte;
  logic w_lane0;
  plcp_pkg::rd_state_t rd_state;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic next_aw_held, next_w_held, next_w_lane0;
  logic [5:0] next_aw_idx;
  logic [7:0] next_w_byte;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  plcp_pkg::rd_state_t next_rd_state;
  logic wr_fire;
  logic rd_fire;
  logic [5:0] rd_idx;

  // Registers and block state.
  logic [7:0] mode_select, overhead_control, tx_path_status, tx_user_octet;
  logic [7:0] irq_enable, error_pattern, rx_user_octet;
  logic [7:0] next_mode_select, next_overhead_control, next_tx_path_status;
  logic [7:0] next_tx_user_octet, next_irq_enable, next_error_pattern;
  logic alarm_sent, next_alarm_sent;
  logic [4:0] alarm_hold, next_alarm_hold;
  logic [3:0] last_parity_count, next_last_parity_count;
  plcp_pkg::tx_overhead_t next_tx_overhead;
  plcp_pkg::tx_timing_mode_t next_timing;

  logic out_of_frame_state, loss_of_frame_state, remote_alarm_state;
  logic next_out_of_frame_state, next_loss_of_frame_state, next_remote_alarm_state;
  logic [3:0] oof_frames, next_oof_frames, alarm_run, next_alarm_run;
  logic [4:0] rx_events, next_rx_events;
  logic [7:0] next_rx_user_octet;
  logic [7:0] irq_status, next_irq_status;
  logic next_irq;

  function automatic logic valid_index(input logic [5:0] idx);
    valid_index = (idx <= plcp_pkg::IDX_RX_USER_OCTET) || (idx == plcp_pkg::IDX_ERROR_PATTERN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: address and data are held until both arrived, then written.

  always_comb begin
    wr_fire = aw_held && w_held && !bvalid_out;
    next_aw_held = aw_held;
    next_aw_idx = aw_idx;
    next_w_held = w_held;
    next_w_byte = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid_out;
    next_bresp = bresp_out;
    if (awvalid_in && awready_out) begin
      next_aw_held = 1'b1;
      next_aw_idx = awaddr_in[7:2];
    end
    if (wvalid_in && wready_out) begin
      next_w_held = 1'b1;
      next_w_byte = wdata_in[7:0];
      next_w_lane0 = wstrb_in[0];
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = valid_index(aw_idx) ? plcp_pkg::RESP_OKAY : plcp_pkg::RESP_SLVERR;
    end else if (bvalid_out && bready_in) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  // Read data is sampled at address acceptance, so a clear-on-read loses nothing.
  always_comb begin
    rd_fire = arvalid_in && arready_out;
    rd_idx = araddr_in[7:2];
    next_rd_state = rd_state;
    next_rdata = rdata_out;
    next_rresp = rresp_out;
    case (rd_state)
      plcp_pkg::RD_IDLE: begin
        if (rd_fire) begin
          next_rd_state = plcp_pkg::RD_RESP;
          next_rresp = valid_index(rd_idx) ? plcp_pkg::RESP_OKAY : plcp_pkg::RESP_SLVERR;
          case (rd_idx)
            plcp_pkg::IDX_MODE_SELECT: next_rdata = {24'h000000, mode_select};
            plcp_pkg::IDX_OVERHEAD_CONTROL: next_rdata = {24'h000000, overhead_control};
            plcp_pkg::IDX_TX_PATH_STATUS: next_rdata = {24'h000000, tx_path_status};
            plcp_pkg::IDX_TX_USER_OCTET: next_rdata = {24'h000000, tx_user_octet};
            plcp_pkg::IDX_RX_STATUS: begin
              // State bits are live.
              // live state bits
              next_rdata = {24'h000000, out_of_frame_state, loss_of_frame_state,
                            remote_alarm_state, rx_events};
            end
            plcp_pkg::IDX_IRQ_STATUS: next_rdata = {24'h000000, irq_status};
            plcp_pkg::IDX_IRQ_ENABLE: next_rdata = {24'h000000, irq_enable};
            plcp_pkg::IDX_RX_USER_OCTET: next_rdata = {24'h000000, rx_user_octet};
            plcp_pkg::IDX_ERROR_PATTERN: next_rdata = {24'h000000, error_pattern};
            default: next_rdata = 32'h00000000;
          endcase
        end
      end
      plcp_pkg::RD_RESP: begin
        if (rready_in) begin
          next_rd_state = plcp_pkg::RD_IDLE;
        end
      end
      default: next_rd_state = plcp_pkg::RD_IDLE;
    endcase
    next_rvalid = (next_rd_state == plcp_pkg::RD_RESP);
    next_arready = !next_rvalid;
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      aw_held <= 1'b0;
      aw_idx <= 6'h00;
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      awready_out <= 1'b0;
      wready_out <= 1'b0;
      bvalid_out <= 1'b0;
      bresp_out <= plcp_pkg::RESP_OKAY;
      rd_state <= plcp_pkg::RD_IDLE;
      arready_out <= 1'b0;
      rvalid_out <= 1'b0;
      rdata_out <= 32'h00000000;
      rresp_out <= plcp_pkg::RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_idx <= next_aw_idx;
      w_held <= next_w_held;
      w_byte <= next_w_byte;
      w_lane0 <= next_w_lane0;
      awready_out <= next_awready;
      wready_out <= next_wready;
      bvalid_out <= next_bvalid;
      bresp_out <= next_bresp;
      rd_state <= next_rd_state;
      arready_out <= next_arready;
      rvalid_out <= next_rvalid;
      rdata_out <= next_rdata;
      rresp_out <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and the transmit overhead built at each frame start.

  always_comb begin
    logic wr_lane;
    logic [3:0] report;
    logic [3:0] auto_report;
    wr_lane = wr_fire && w_lane0;
    auto_report = 4'h0;
    report = 4'h0;
    next_mode_select = mode_select;
    next_overhead_control = overhead_control;
    next_tx_path_status = tx_path_status;
    next_tx_user_octet = tx_user_octet;
    next_irq_enable = irq_enable;
    next_error_pattern = error_pattern;
    next_alarm_sent = alarm_sent;
    next_alarm_hold = alarm_hold;
    next_tx_overhead = tx_overhead_out;
    if (wr_lane) begin
      case (aw_idx)
        plcp_pkg::IDX_MODE_SELECT: next_mode_select = w_byte & plcp_pkg::MODE_SELECT_MASK;
        plcp_pkg::IDX_OVERHEAD_CONTROL: next_overhead_control = w_byte;
        plcp_pkg::IDX_TX_PATH_STATUS: next_tx_path_status = w_byte;
        plcp_pkg::IDX_TX_USER_OCTET: next_tx_user_octet = w_byte;
        plcp_pkg::IDX_IRQ_ENABLE: next_irq_enable = w_byte;
        plcp_pkg::IDX_ERROR_PATTERN: next_error_pattern = w_byte;
        default: next_mode_select = mode_select;
      endcase
    end
    case (mode_select[plcp_pkg::TIMING_MSB:plcp_pkg::TIMING_LSB])
      2'b00: next_timing = plcp_pkg::TIMING_RX_LOCK;
      2'b10: next_timing = plcp_pkg::TIMING_FREE_RUN;
      default: next_timing = plcp_pkg::TIMING_EXT_8K;
    endcase
    // Receive counts above the legal maximum are clamped before being reported.
    auto_report = (last_parity_count > plcp_pkg::REPORT_MAX_COUNT) ?
                  plcp_pkg::REPORT_MAX_COUNT : last_parity_count;
    report = overhead_control[plcp_pkg::AUTO_REPORT_BIT] ? auto_report :
             tx_path_status[plcp_pkg::REPORT_MSB:plcp_pkg::REPORT_LSB];
    if (overhead_control[plcp_pkg::INJ_REPORT_BIT]) begin
      report = error_pattern[plcp_pkg::REPORT_MSB:plcp_pkg::REPORT_LSB];
    end
    if (tx_frame_start_in) begin
      if (alarm_hold < plcp_pkg::TX_ALARM_HOLD_FRAMES) begin
        next_alarm_hold = alarm_hold + 5'h01;
      end else if (tx_path_status[plcp_pkg::ALARM_BIT] != alarm_sent) begin
        next_alarm_sent = tx_path_status[plcp_pkg::ALARM_BIT];
        next_alarm_hold = 5'h01;
      end
      next_tx_overhead.framing_1 = overhead_control[plcp_pkg::ZERO_FRAMING_BIT] ? 8'h00 :
        (overhead_control[plcp_pkg::INJ_FRAMING_BIT] ? ~plcp_pkg::FRAMING_OCTET_1 :
         plcp_pkg::FRAMING_OCTET_1);
      next_tx_overhead.framing_2 = overhead_control[plcp_pkg::ZERO_FRAMING_BIT] ? 8'h00 :
        (overhead_control[plcp_pkg::INJ_FRAMING_BIT] ? ~plcp_pkg::FRAMING_OCTET_2 :
         plcp_pkg::FRAMING_OCTET_2);
      next_tx_overhead.poi_zero = overhead_control[plcp_pkg::ZERO_POI_BIT];
      next_tx_overhead.parity = overhead_control[plcp_pkg::ZERO_PARITY_BIT] ? 8'h00 :
        (overhead_control[plcp_pkg::INJ_PARITY_BIT] ? (tx_parity_in ^ error_pattern) :
         tx_parity_in);
      next_tx_overhead.cycle_stuff = overhead_control[plcp_pkg::ZERO_STUFF_BIT] ? 8'h00 :
                                     tx_cycle_stuff_in;
      next_tx_overhead.path_status = {report, next_alarm_sent,
                                      tx_path_status[plcp_pkg::LINK_MSB:0]};
      next_tx_overhead.user_octet = tx_user_octet;
      // Insertion is done once the frame has been built, so the request bits drop here.
      // self-clear wins
      next_overhead_control = next_overhead_control & ~plcp_pkg::INJECT_MASK;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      mode_select <= plcp_pkg::RST_MODE_SELECT;
      overhead_control <= plcp_pkg::RST_OVERHEAD_CONTROL;
      tx_path_status <= plcp_pkg::RST_TX_PATH_STATUS;
      tx_user_octet <= plcp_pkg::RST_TX_USER_OCTET;
      irq_enable <= plcp_pkg::RST_IRQ_ENABLE;
      error_pattern <= plcp_pkg::RST_ERROR_PATTERN;
      alarm_sent <= 1'b0;
      alarm_hold <= plcp_pkg::TX_ALARM_HOLD_FRAMES;
      tx_overhead_out <= '0;
      plcp_mapping_select_out <= 1'b0;
      tx_frame_timing_source_out <= plcp_pkg::TIMING_RX_LOCK;
    end else begin
      mode_select <= next_mode_select;
      overhead_control <= next_overhead_control;
      tx_path_status <= next_tx_path_status;
      tx_user_octet <= next_tx_user_octet;
      irq_enable <= next_irq_enable;
      error_pattern <= next_error_pattern;
      alarm_sent <= next_alarm_sent;
      alarm_hold <= next_alarm_hold;
      tx_overhead_out <= next_tx_overhead;
      plcp_mapping_select_out <= mode_select[plcp_pkg::MAP_SEL_BIT];
      tx_frame_timing_source_out <= next_timing;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive state, event status and interrupt status.

  always_comb begin
    logic [3:0] rx_report;
    logic [4:0] events;
    logic new_user;
    logic [7:0] edges;
    rx_report = rx_info_in.path_status[plcp_pkg::REPORT_MSB:plcp_pkg::REPORT_LSB];
    events = 5'h00;
    new_user = 1'b0;
    edges = 8'h00;
    next_oof_frames = oof_frames;
    next_loss_of_frame_state = loss_of_frame_state;
    next_remote_alarm_state = remote_alarm_state;
    next_alarm_run = alarm_run;
    next_rx_user_octet = rx_user_octet;
    next_last_parity_count = last_parity_count;
    next_out_of_frame_state = !rx_info_in.in_frame;
    if (rx_info_in.in_frame) begin
      next_oof_frames = 4'h0;
      next_loss_of_frame_state = 1'b0;
    end else if (rx_info_in.frame_pulse && oof_frames < plcp_pkg::LOF_FRAMES) begin
      next_oof_frames = oof_frames + 4'h1;
      if (next_oof_frames == plcp_pkg::LOF_FRAMES) begin
        next_loss_of_frame_state = 1'b1;
      end
    end
    if (rx_info_in.frame_pulse && rx_info_in.in_frame) begin
      if (rx_info_in.path_status[plcp_pkg::ALARM_BIT] != remote_alarm_state) begin
        next_alarm_run = alarm_run + 4'h1;
        if (next_alarm_run == plcp_pkg::ALARM_FRAMES) begin
          next_remote_alarm_state = !remote_alarm_state;
          next_alarm_run = 4'h0;
        end
      end else begin
        next_alarm_run = 4'h0;
      end
      next_last_parity_count = rx_info_in.parity_err_count;
      events[4] = rx_info_in.framing_err || rx_info_in.poi_err;
      events[3] = (rx_info_in.parity_err_count != 4'h0);
      events[2] = (rx_report != 4'h0) && (rx_report <= plcp_pkg::REPORT_MAX_COUNT);
      events[1] = (rx_report == plcp_pkg::REPORT_ALL_ONES);
      events[0] = (rx_report > plcp_pkg::REPORT_MAX_COUNT) &&
                  (rx_report != plcp_pkg::REPORT_ALL_ONES);
      new_user = (rx_info_in.user_octet != rx_user_octet);
      next_rx_user_octet = rx_info_in.user_octet;
    end
    // A fresh event in the read cycle survives the clear.
    // clear on read
    next_rx_events = ((rd_fire && rd_idx == plcp_pkg::IDX_RX_STATUS) ? 5'h00 : rx_events) |
                     events;
    edges[7] = next_out_of_frame_state ^ out_of_frame_state;
    edges[6] = next_loss_of_frame_state ^ loss_of_frame_state;
    edges[5] = next_remote_alarm_state ^ remote_alarm_state;
    edges[4] = next_rx_events[4] && !rx_events[4];
    edges[3] = next_rx_events[3] && !rx_events[3];
    edges[2] = next_rx_events[2] && !rx_events[2];
    edges[1] = (next_rx_events[1] && !rx_events[1]) || (next_rx_events[0] && !rx_events[0]);
    edges[0] = new_user;
    next_irq_status = ((rd_fire && rd_idx == plcp_pkg::IDX_IRQ_STATUS) ? 8'h00 : irq_status) |
                      edges;
    next_irq = |(next_irq_status & next_irq_enable);
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      out_of_frame_state <= 1'b0;
      loss_of_frame_state <= 1'b0;
      remote_alarm_state <= 1'b0;
      oof_frames <= 4'h0;
      alarm_run <= 4'h0;
      rx_events <= 5'h00;
      rx_user_octet <= 8'h00;
      last_parity_count <= 4'h0;
      irq_status <= 8'h00;
      irq_out <= 1'b0;
    end else begin
      out_of_frame_state <= next_out_of_frame_state;
      loss_of_frame_state <= next_loss_of_frame_state;
      remote_alarm_state <= next_remote_alarm_state;
      oof_frames <= next_oof_frames;
      alarm_run <= next_alarm_run;
      rx_events <= next_rx_events;
      rx_user_octet <= next_rx_user_octet;
      last_parity_count <= next_last_parity_count;
      irq_status <= next_irq_status;
      irq_out <= next_irq;
    end
  end

endmodule

// ===== tb/far_end_terminal.sv
`timescale 1ns/1ns
module far_end_terminal (
  input wire logic mclk_in, // Clock
  input wire logic [3:0] err_in, // Parity errors to report
  input wire logic [16:0] rx_in, // Framing found, G1 and F1 received
  output plcp_pkg::rx_frame_info_t rx_info_out, // Received frame
  output logic tx_start_out // Transmit frame start
);
  logic [3:0] phase = 4'h0;
  // Frames of 16 cycles keep the run short; framing, G1 and F1 come from the bench.
  always @(posedge mclk_in) phase <= phase + 4'h1;
  assign tx_start_out = (phase == 4'h0);
  assign rx_info_out = '{frame_pulse: phase == 4'h8, in_frame: rx_in[16],
    parity_err_count: err_in, path_status: rx_in[15:8], user_octet: rx_in[7:0], default: '0};
endmodule

// ===== tb/plcp_ctrl_status_monitor.sv
`timescale 1ns/1ns
module plcp_ctrl_status_monitor (
  input wire logic mclk_in, // Clock
  input wire logic reset_in, // Reset
  input wire logic awready_out, // Ready
  input wire logic bvalid_out, // Response
  input wire logic bready_in, // Accept
  input wire logic arvalid_in, // Request
  input wire logic arready_out, // Ready
  input wire logic rvalid_out, // Response
  input wire logic rready_in, // Accept
  input wire logic tx_frame_start_in, // Frame start
  input wire plcp_pkg::tx_overhead_t tx_overhead_out // Overhead
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  sequence s_b_done; bvalid_out && bready_in; endsequence
  sequence s_r_done; rvalid_out && rready_in; endsequence
  a_bvalid_held: assert property (bvalid_out && !bready_in |=> bvalid_out)
    else $error("bvalid fell");
  a_rvalid_held: assert property (rvalid_out && !rready_in |=> rvalid_out)
    else $error("rvalid fell");
  a_read_answer: assert property (arvalid_in && arready_out |=> rvalid_out)
    else $error("read late");
  a_b_retire: assert property (s_b_done |=> !bvalid_out ##[0:1] awready_out)
    else $error("write retire");
  a_r_retire: assert property (s_r_done |=> !rvalid_out ##[0:1] arready_out)
    else $error("read retire");
  a_aw_blocked: assert property (bvalid_out |-> !awready_out)
    else $error("aw open");
  a_tx_stands: assert property (!tx_frame_start_in |=> $stable(tx_overhead_out))
    else $error("overhead moved");
  a_framing_vals: assert property (tx_overhead_out.framing_1 inside {8'hf6, 8'h09, 8'h00})
    else $error("framing octet");
endmodule
bind plcp_ctrl_status plcp_ctrl_status_monitor mon (.mclk_in, .reset_in, .awready_out,
  .bvalid_out, .bready_in, .arvalid_in, .arready_out, .rvalid_out, .rready_in,
  .tx_frame_start_in, .tx_overhead_out);

// ===== tb/plcp_ctrl_status_tb.sv
`timescale 1ns/1ns
module plcp_ctrl_status_tb;
  logic mclk_in = 1'b0, reset_in = 1'b1, awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0;
  logic arvalid_in = 1'b0, rready_in = 1'b0, awready_out, wready_out, bvalid_out, arready_out;
  logic rvalid_out, irq_out, tx_frame_start_in, plcp_mapping_select_out;
  logic [7:0] awaddr_in = 8'h0, araddr_in = 8'h0, tx_parity_in = 8'h3c, tx_cycle_stuff_in = 8'h5a;
  logic [31:0] wdata_in = 32'h0, rdata_out, v;
  logic [3:0] wstrb_in = 4'h1, err = 4'h0;
  logic [16:0] far = 17'h10000;
  logic [1:0] bresp_out, rresp_out, rsp;
  logic [7:0] rst [4] = '{8'h00, 8'h08, 8'hf0, 8'h00};
  plcp_pkg::rx_frame_info_t rx_info_in;
  plcp_pkg::tx_overhead_t tx_overhead_out;
  plcp_pkg::tx_timing_mode_t tx_frame_timing_source_out;
  int failures = 0, check_count = 0, cycles = 0;
  always #2 mclk_in = ~mclk_in;
  far_end_terminal peer (.mclk_in, .err_in(err), .rx_in(far), .rx_info_out(rx_info_in),
    .tx_start_out(tx_frame_start_in));
  plcp_ctrl_status dut (.mclk_in, .reset_in, .awvalid_in, .awready_out, .awaddr_in, .wvalid_in,
    .wready_out, .wdata_in, .wstrb_in, .bvalid_out, .bready_in, .bresp_out, .arvalid_in,
    .arready_out, .araddr_in, .rvalid_out, .rready_in, .rdata_out, .rresp_out, .rx_info_in,
    .tx_frame_start_in, .tx_parity_in, .tx_cycle_stuff_in, .tx_overhead_out,
    .plcp_mapping_select_out, .tx_frame_timing_source_out, .irq_out);
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    @(posedge mclk_in);
    {awaddr_in, wdata_in} <= {idx, 2'h0, 24'h0, d};
    {awvalid_in, wvalid_in, bready_in} <= 3'h7;
    do begin
      @(posedge mclk_in);
      if (awready_out) awvalid_in <= 1'b0;
      if (wready_out) wvalid_in <= 1'b0;
    end while (bvalid_out !== 1'b1);
    rsp = bresp_out;
    bready_in <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] idx, output logic [31:0] d);
    @(posedge mclk_in);
    araddr_in <= {idx, 2'h0};
    {arvalid_in, rready_in} <= 2'h3;
    do begin
      @(posedge mclk_in);
      if (arready_out) arvalid_in <= 1'b0;
    end while (rvalid_out !== 1'b1);
    {d, rsp} = {rdata_out, rresp_out};
    rready_in <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge mclk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(i[5:0], v);
      chk(v, {24'h0, rst[i]});
    end
    rd(6'h3f, v);
    chk({v, rsp}, 34'h2);
    wr(6'h3f, 8'h00);
    chk(rsp, 2'h2);
    for (int i = 0; i < 4; i++) begin
      wr(6'h00, {1'b1, i[1:0], 5'h00});
      @(negedge mclk_in);
      chk({plcp_mapping_select_out, tx_frame_timing_source_out},
        {1'b1, (i[1:0] == 2'h3) ? 2'h1 : i[1:0]});
    end
    wr(6'h01, 8'h00);
    wr(6'h02, 8'h25);
    wr(6'h03, 8'ha5);
    repeat (40) @(posedge mclk_in);
    chk(tx_overhead_out, {16'hf628, 1'b0, 32'h3c5a25a5});
    wr(6'h01, 8'hf0);
    repeat (40) @(posedge mclk_in);
    chk(tx_overhead_out, {17'h1, 16'h0, 16'h25a5});
    wr(6'h0c, 8'h90);
    // Writing just after a frame start keeps the injection clear of the next start.
    @(posedge mclk_in iff tx_frame_start_in);
    wr(6'h01, 8'h07);
    @(posedge mclk_in iff tx_frame_start_in);
    @(negedge mclk_in);
    chk(tx_overhead_out, {16'h09d7, 1'b0, 32'hac5a95a5});
    rd(6'h01, v);
    chk(v, 32'h0);
    rd(6'h04, v);
    rd(6'h05, v);
    wr(6'h06, 8'h08);
    err <= 4'h2;
    repeat (20) @(posedge mclk_in);
    err <= 4'h0;
    repeat (4) @(posedge mclk_in);
    chk(irq_out, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rd(6'h04 + {5'h0, i[1]}, v);
      chk(v, i[0] ? 32'h0 : 32'h08);
    end
    wr(6'h02, 8'h2d);
    repeat (20) @(posedge mclk_in);
    chk(tx_overhead_out.path_status, 8'h2d);
    wr(6'h02, 8'h25);
    repeat (40) @(posedge mclk_in);
    chk(tx_overhead_out.path_status, 8'h2d);
    repeat (320) @(posedge mclk_in);
    chk(tx_overhead_out.path_status, 8'h25);
    far <= 17'h1083c;
    repeat (180) @(posedge mclk_in);
    rd(6'h07, v);
    chk(v, 32'h3c);
    rd(6'h04, v);
    chk(v, 32'h20);
    rd(6'h05, v);
    chk(v, 32'h21);
    far <= 17'h0083c;
    repeat (150) @(posedge mclk_in);
    rd(6'h04, v);
    chk(v, 32'he0);
    rd(6'h05, v);
    chk(v, 32'hc0);
    far <= 17'h1083c;
    repeat (4) @(posedge mclk_in);
    rd(6'h04, v);
    chk(v, 32'h20);
    rd(6'h05, v);
    chk(v, 32'hc0);
    end_of_test();
  end
endmodule
